// ==== src/pdam_pkg.sv ====
package pdam_pkg;

  // ----------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------
  localparam int WORD_W   = 16;
  localparam int ADDR_W   = 13;
  localparam int BITNUM_W = 7;
  localparam int IDX_W    = 14;

  typedef logic [3:0]        pdam_area_t;
  typedef logic [2:0]        pdam_err_t;
  typedef logic [IDX_W-1:0]  pdam_idx_t;
  typedef logic [ADDR_W-1:0] pdam_addr_t;

  // ----------------------------------------------------------------
  // Area selector codes on the access port
  // ----------------------------------------------------------------
  localparam pdam_area_t AREA_INT_SPC = 4'h0;
  localparam pdam_area_t AREA_AUX     = 4'h1;
  localparam pdam_area_t AREA_DM      = 4'h2;
  localparam pdam_area_t AREA_HOLD    = 4'h3;
  localparam pdam_area_t AREA_TC      = 4'h4;
  localparam pdam_area_t AREA_TC_SET  = 4'h5;
  localparam pdam_area_t AREA_LINK    = 4'h6;
  localparam pdam_area_t AREA_TEMP    = 4'h7;
  localparam pdam_area_t AREA_FM      = 4'h8;
  localparam pdam_area_t AREA_TRACE   = 4'h9;

  // ----------------------------------------------------------------
  // Area limits (last valid word or number)
  // ----------------------------------------------------------------
  localparam pdam_addr_t INT_LAST      = 13'd236;
  localparam pdam_addr_t SPC_LAST      = 13'd255;
  localparam pdam_addr_t AUX_LAST      = 13'd27;
  localparam pdam_addr_t DM_LAST_SMALL = 13'd4095;
  localparam pdam_addr_t DM_LAST_LARGE = 13'd6655;
  localparam pdam_addr_t HOLD_LAST     = 13'd99;
  localparam pdam_addr_t TC_LAST       = 13'd511;
  localparam pdam_addr_t LINK_LAST     = 13'd63;
  localparam pdam_addr_t TEMP_LAST     = 13'd7;
  localparam pdam_addr_t FM_LAST_SMALL = 13'd999;
  localparam pdam_addr_t FM_LAST_LARGE = 13'd1999;
  localparam pdam_addr_t TRACE_LAST    = 13'd249;
  localparam int         TRACE_DEPTH   = 250;
  localparam logic [BITNUM_W-1:0] BIT_LAST = 7'd15;

  // ----------------------------------------------------------------
  // Flat word store bases
  // ----------------------------------------------------------------
  localparam pdam_idx_t BASE_AUX   = 14'd256;
  localparam pdam_idx_t BASE_HOLD  = 14'd284;
  localparam pdam_idx_t BASE_LINK  = 14'd384;
  localparam pdam_idx_t BASE_TC_PV = 14'd448;
  localparam pdam_idx_t BASE_TC_SV = 14'd960;
  localparam pdam_idx_t BASE_DM    = 14'd1472;
  localparam pdam_idx_t BASE_FM    = 14'd8128;
  localparam int        MEM_WORDS  = 10128;

  // ----------------------------------------------------------------
  // System flag word and file memory protect bit
  // ----------------------------------------------------------------
  localparam pdam_idx_t  SPC_FLAG_WORD = 14'd255;
  localparam pdam_addr_t AUX_FMWP_WORD = 13'd27;
  localparam int         AUX_FMWP_BIT  = 15;

  // ----------------------------------------------------------------
  // Error codes
  // ----------------------------------------------------------------
  localparam pdam_err_t ERR_NONE      = 3'h0;
  localparam pdam_err_t ERR_RANGE     = 3'h1;
  localparam pdam_err_t ERR_WORD_ONLY = 3'h2;
  localparam pdam_err_t ERR_BIT_ONLY  = 3'h3;
  localparam pdam_err_t ERR_BITNUM    = 3'h4;
  localparam pdam_err_t ERR_READONLY  = 3'h5;

endpackage

// ==== src/pdam_dec_if.sv ====
`timescale 1ns/1ps
interface pdam_dec_if;
  pdam_pkg::pdam_area_t              area;
  pdam_pkg::pdam_addr_t              addr;
  logic [pdam_pkg::BITNUM_W-1:0]     bit_num;
  logic                              bit_mode;
  logic                              wr;
  logic                              model_large;
  logic                              fm_large;
  logic                              fm_wp;
  logic                              ok;
  pdam_pkg::pdam_err_t               err;
  pdam_pkg::pdam_idx_t               index;
  logic                              is_temp;
  logic                              is_tc_flag;
  logic                              is_trace;

  modport dec (
    input  area, addr, bit_num, bit_mode, wr, model_large, fm_large, fm_wp,
    output ok, err, index, is_temp, is_tc_flag, is_trace
  );
  modport use_side (
    output area, addr, bit_num, bit_mode, wr, model_large, fm_large, fm_wp,
    input  ok, err, index, is_temp, is_tc_flag, is_trace
  );
endinterface

// ==== src/pdam_decode.sv ====
`timescale 1ns/1ps
module pdam_decode (
  pdam_dec_if.dec d
);

  pdam_pkg::pdam_addr_t lim;
  pdam_pkg::pdam_idx_t  base;
  logic                 word_only;
  logic                 bit_only;
  logic                 read_only;

  // ----------------------------------------------------------------
  // Area limits and access kinds
  // ----------------------------------------------------------------
  always_comb begin
    lim       = '0;
    base      = '0;
    word_only = 1'b0;
    bit_only  = 1'b0;
    read_only = 1'b0;
    d.is_temp    = 1'b0;
    d.is_tc_flag = 1'b0;
    d.is_trace   = 1'b0;
    case (d.area)
      pdam_pkg::AREA_INT_SPC: begin
        lim       = pdam_pkg::SPC_LAST;
        read_only = (d.addr == pdam_pkg::pdam_addr_t'(pdam_pkg::SPC_FLAG_WORD));
      end
      pdam_pkg::AREA_AUX: begin
        lim  = pdam_pkg::AUX_LAST;
        base = pdam_pkg::BASE_AUX;
      end
      pdam_pkg::AREA_DM: begin
        lim       = d.model_large ? pdam_pkg::DM_LAST_LARGE : pdam_pkg::DM_LAST_SMALL;
        base      = pdam_pkg::BASE_DM;
        word_only = 1'b1;
      end
      pdam_pkg::AREA_HOLD: begin
        lim  = pdam_pkg::HOLD_LAST;
        base = pdam_pkg::BASE_HOLD;
      end
      pdam_pkg::AREA_TC: begin
        lim          = pdam_pkg::TC_LAST;
        base         = pdam_pkg::BASE_TC_PV;
        d.is_tc_flag = d.bit_mode;
        read_only    = d.bit_mode;
      end
      pdam_pkg::AREA_TC_SET: begin
        lim       = pdam_pkg::TC_LAST;
        base      = pdam_pkg::BASE_TC_SV;
        word_only = 1'b1;
      end
      pdam_pkg::AREA_LINK: begin
        lim  = pdam_pkg::LINK_LAST;
        base = pdam_pkg::BASE_LINK;
      end
      pdam_pkg::AREA_TEMP: begin
        lim       = pdam_pkg::TEMP_LAST;
        bit_only  = 1'b1;
        d.is_temp = 1'b1;
      end
      pdam_pkg::AREA_FM: begin
        lim       = d.fm_large ? pdam_pkg::FM_LAST_LARGE : pdam_pkg::FM_LAST_SMALL;
        base      = pdam_pkg::BASE_FM;
        word_only = 1'b1;
        read_only = d.fm_wp;
      end
      pdam_pkg::AREA_TRACE: begin
        lim        = pdam_pkg::TRACE_LAST;
        word_only  = 1'b1;
        read_only  = 1'b1;
        d.is_trace = 1'b1;
      end
      default: lim = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Error priority: range, kind, bit number, write protection
  // ----------------------------------------------------------------
  always_comb begin
    d.index = base + pdam_pkg::pdam_idx_t'(d.addr);
    if (d.area > pdam_pkg::AREA_TRACE || d.addr > lim) begin
      d.err = pdam_pkg::ERR_RANGE;
    end else if (word_only && d.bit_mode) begin
      d.err = pdam_pkg::ERR_WORD_ONLY;
    end else if (bit_only && !d.bit_mode) begin
      d.err = pdam_pkg::ERR_BIT_ONLY;
    end else if (d.bit_mode && !d.is_temp && !d.is_tc_flag
                 && d.bit_num > pdam_pkg::BIT_LAST) begin
      d.err = pdam_pkg::ERR_BITNUM;
    end else if (d.wr && read_only) begin
      d.err = pdam_pkg::ERR_READONLY;
    end else begin
      d.err = pdam_pkg::ERR_NONE;
    end
    d.ok = (d.err == pdam_pkg::ERR_NONE);
  end

endmodule

// ==== src/pdam_top.sv ====
`timescale 1ns/1ps
module pdam_top (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST_N,
  input  wire logic                          REQ,
  input  wire logic                          WR,
  input  wire logic                          BIT_MODE,
  input  wire logic [3:0]                    AREA,
  input  wire logic [pdam_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [pdam_pkg::BITNUM_W-1:0] BIT_NUM,
  input  wire logic [pdam_pkg::WORD_W-1:0]   WDATA,
  input  wire logic                          WBIT,
  input  wire logic                          MODEL_LARGE,
  input  wire logic                          FM_LARGE,
  input  wire logic                          RUN,
  input  wire logic [pdam_pkg::WORD_W-1:0]   SYS_FLAGS,
  input  wire logic                          TRACE_VLD,
  input  wire logic [pdam_pkg::WORD_W-1:0]   TRACE_WORD,
  output logic                               ACK,
  output logic [pdam_pkg::WORD_W-1:0]        RDATA,
  output logic                               RBIT,
  output logic [2:0]                         ERR,
  output logic                               BUSY,
  output logic                               FM_PROTECT,
  output logic [7:0]                         TEMP_BITS
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                         clr_busy;
    logic [7:0]                   clr_ptr;
    logic                         run_q;
    logic [pdam_pkg::WORD_W-1:0]  flags;
    logic [7:0]                   temp;
    logic                         fm_wp;
    logic [7:0]                   tr_ptr;
    logic                         ack;
    logic [pdam_pkg::WORD_W-1:0]  rdata;
    logic                         rbit;
    pdam_pkg::pdam_err_t          err;
  } pdam_st_s;

  pdam_st_s st;
  pdam_st_s next_st;

  // Plain arrays; no reset so holding words keep their value
  logic [pdam_pkg::WORD_W-1:0] mem   [pdam_pkg::MEM_WORDS];
  logic [pdam_pkg::WORD_W-1:0] trace [pdam_pkg::TRACE_DEPTH];

  logic                        mem_we;
  pdam_pkg::pdam_idx_t         mem_idx;
  logic [pdam_pkg::WORD_W-1:0] mem_wdata;
  logic [pdam_pkg::WORD_W-1:0] rd_word;
  logic [pdam_pkg::WORD_W-1:0] bit_merged;
  logic                        accept;

  pdam_dec_if dif ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign dif.area        = AREA;
  assign dif.addr        = ADDR;
  assign dif.bit_num     = BIT_NUM;
  assign dif.bit_mode    = BIT_MODE;
  assign dif.wr          = WR;
  assign dif.model_large = MODEL_LARGE;
  assign dif.fm_large    = FM_LARGE;
  assign dif.fm_wp       = st.fm_wp;

  pdam_decode u_decode (
    .d (dif.dec)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    if (dif.ok) begin
      if (dif.is_trace) begin
        rd_word = trace[dif.addr[7:0]];
      end else if (dif.area == pdam_pkg::AREA_INT_SPC
                   && dif.index == pdam_pkg::SPC_FLAG_WORD) begin
        // Flag word lags the system by one cycle
        rd_word = st.flags;
      end else if (!dif.is_temp) begin
        rd_word = mem[dif.index];
      end
    end
    bit_merged = rd_word;
    bit_merged[BIT_NUM[3:0]] = WBIT;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.run_q = RUN;
    next_st.flags = SYS_FLAGS;
    mem_we        = 1'b0;
    mem_idx       = '0;
    mem_wdata     = '0;
    accept        = REQ && !st.clr_busy;

    // ----------------------------------------------------------------
    // Clear sweep
    // ----------------------------------------------------------------
    // Sweep owns the write port, so requests are not accepted and get no ACK while it runs
    if (st.clr_busy) begin
      mem_we    = 1'b1;
      mem_idx   = pdam_pkg::pdam_idx_t'(st.clr_ptr);
      mem_wdata = '0;
      next_st.clr_ptr = st.clr_ptr + 8'h01;
      if (st.clr_ptr == pdam_pkg::INT_LAST[7:0]) begin
        next_st.clr_busy = 1'b0;
        next_st.clr_ptr  = '0;
      end
    end else if (st.run_q && !RUN) begin
      next_st.clr_busy = 1'b1;
      next_st.clr_ptr  = '0;
    end

    // ----------------------------------------------------------------
    // Access
    // ----------------------------------------------------------------
    if (accept) begin
      next_st.ack   = 1'b1;
      next_st.err   = dif.err;
      next_st.rdata = rd_word;
      if (dif.is_temp) begin
        next_st.rbit = st.temp[dif.addr[2:0]];
      end else if (dif.is_tc_flag) begin
        // No timer engine here; a zero present value reads as done
        next_st.rbit = (rd_word == '0);
      end else begin
        next_st.rbit = rd_word[BIT_NUM[3:0]];
      end
      if (WR && dif.ok) begin
        if (dif.is_temp) begin
          next_st.temp[dif.addr[2:0]] = WBIT;
        end else begin
          mem_we    = 1'b1;
          mem_idx   = dif.index;
          mem_wdata = BIT_MODE ? bit_merged : WDATA;
          if (dif.area == pdam_pkg::AREA_AUX && dif.addr == pdam_pkg::AUX_FMWP_WORD) begin
            next_st.fm_wp = mem_wdata[pdam_pkg::AUX_FMWP_BIT];
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // Trace pointer
    // ----------------------------------------------------------------
    // Pointer wraps; the oldest entry is overwritten first
    if (TRACE_VLD) begin
      if (st.tr_ptr == pdam_pkg::TRACE_LAST[7:0]) begin
        next_st.tr_ptr = '0;
      end else begin
        next_st.tr_ptr = st.tr_ptr + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset starts a clear sweep, standing in for a power interruption
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st <= '{clr_busy: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wdata;
    end
    if (TRACE_VLD) begin
      trace[st.tr_ptr] <= TRACE_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Straight from registers; no logic after the flops
  assign ACK        = st.ack;
  assign RDATA      = st.rdata;
  assign RBIT       = st.rbit;
  assign ERR        = st.err;
  assign BUSY       = st.clr_busy;
  assign FM_PROTECT = st.fm_wp;
  assign TEMP_BITS  = st.temp;

endmodule

// ==== sim/pdam_cpu_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Program execution engine model
// ----------------------------------------------------------------
module pdam_cpu_model (
  input  wire logic                          CLK_SYS,
  output logic                               REQ,
  output logic                               WR,
  output logic                               BIT_MODE,
  output logic [3:0]                         AREA,
  output logic [pdam_pkg::ADDR_W-1:0]        ADDR,
  output logic [pdam_pkg::BITNUM_W-1:0]      BIT_NUM,
  output logic [pdam_pkg::WORD_W-1:0]        WDATA,
  output logic                               WBIT
);
  initial begin
    {REQ, WR, BIT_MODE, AREA, ADDR, BIT_NUM, WDATA, WBIT} = '0;
  end

  // One access held for one edge; bit value rides on data bit 0
  task automatic access(input logic w, input logic b, input logic [3:0] a,
                        input logic [12:0] ad, input logic [6:0] bn, input logic [15:0] d);
    @(posedge CLK_SYS);
    #1;
    {REQ, WR, BIT_MODE, AREA, ADDR, BIT_NUM, WDATA, WBIT} = {1'b1, w, b, a, ad, bn, d, d[0]};
    @(posedge CLK_SYS);
    #1;
    REQ   = 1'b0;
    WDATA = ~WDATA; // Stale data must not look valid
  endtask
endmodule

// ==== sim/pdam_chk_sva.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module pdam_chk (
  input wire logic                          CLK_SYS,
  input wire logic                          RST_N,
  input wire logic                          REQ,
  input wire logic                          WR,
  input wire logic                          BIT_MODE,
  input wire logic [3:0]                    AREA,
  input wire logic [pdam_pkg::ADDR_W-1:0]   ADDR,
  input wire logic [pdam_pkg::BITNUM_W-1:0] BIT_NUM,
  input wire logic                          RUN,
  input wire logic                          ACK,
  input wire logic [2:0]                    ERR,
  input wire logic                          BUSY,
  input wire logic                          FM_PROTECT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  localparam int SWEEP_LEN = 237;
  logic       take;
  logic       run_d;
  logic       run_seen;
  logic [8:0] sweep_cnt;

  assign take = REQ && !BUSY;

  // Sweep length judged only after a stop; reset sweep start is loosely fixed
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      run_d     <= 1'b1;
      run_seen  <= 1'b0;
      sweep_cnt <= 9'h000;
    end else begin
      run_d     <= RUN;
      run_seen  <= (run_d && !RUN && !BUSY) || (run_seen && BUSY);
      sweep_cnt <= BUSY ? sweep_cnt + 9'h001 : 9'h000;
    end
  end

  ack_follows_take_a:
    assert property (ACK == $past(take)) else $error("ack not tied to accepted request");
  dm_bit_refused_a:
    assert property (take && AREA == pdam_pkg::AREA_DM && BIT_MODE
      && ADDR <= pdam_pkg::DM_LAST_SMALL
      |=> ERR == pdam_pkg::ERR_WORD_ONLY) else $error("data memory bit access accepted");
  temp_word_refused_a:
    assert property (take && AREA == pdam_pkg::AREA_TEMP && !BIT_MODE
      && ADDR <= pdam_pkg::TEMP_LAST
      |=> ERR == pdam_pkg::ERR_BIT_ONLY) else $error("temporary word access accepted");
  bitnum_refused_a:
    assert property (take && AREA == pdam_pkg::AREA_HOLD && BIT_MODE && ADDR <= pdam_pkg::HOLD_LAST
      && BIT_NUM > pdam_pkg::BIT_LAST |=> ERR == pdam_pkg::ERR_BITNUM)
      else $error("bit number above 15 accepted");
  link_range_a:
    assert property (take && AREA == pdam_pkg::AREA_LINK && ADDR > pdam_pkg::LINK_LAST
      |=> ERR == pdam_pkg::ERR_RANGE) else $error("link word out of range accepted");
  int_range_a:
    assert property (take && AREA == pdam_pkg::AREA_INT_SPC && ADDR > pdam_pkg::SPC_LAST
      |=> ERR == pdam_pkg::ERR_RANGE) else $error("word above 255 accepted");
  flag_write_a:
    assert property (take && WR && !BIT_MODE && AREA == pdam_pkg::AREA_INT_SPC
      && ADDR == pdam_pkg::SPC_LAST |=> ERR == pdam_pkg::ERR_READONLY)
      else $error("flag word write accepted");
  fm_protect_a:
    assert property (take && WR && !BIT_MODE && AREA == pdam_pkg::AREA_FM && FM_PROTECT
      && ADDR <= pdam_pkg::FM_LAST_SMALL |=> ERR == pdam_pkg::ERR_READONLY)
      else $error("protected file memory written");
  sweep_start_a:
    assert property ($fell(RUN) && !BUSY |=> BUSY [*8]) else $error("stop did not start clear");
  sweep_len_a:
    assert property (run_seen && !BUSY && $past(BUSY) |-> sweep_cnt == SWEEP_LEN)
      else $error("clear sweep length wrong");

  cover property (take && WR && AREA == pdam_pkg::AREA_HOLD);
  cover property (run_seen && !BUSY);
  cover property (take && WR && BIT_MODE && AREA == pdam_pkg::AREA_TEMP);
endmodule

bind pdam_top pdam_chk pdam_chk_i (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ(REQ), .WR(WR), .BIT_MODE(BIT_MODE), .AREA(AREA),
  .ADDR(ADDR), .BIT_NUM(BIT_NUM), .RUN(RUN), .ACK(ACK), .ERR(ERR), .BUSY(BUSY),
  .FM_PROTECT(FM_PROTECT)
);

// ==== sim/pdam_top_tb.sv ====
`timescale 1ns/1ps
module pdam_top_tb;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        CLK_SYS, RST_N, REQ, WR, BIT_MODE, WBIT, ACK, RBIT, BUSY, FM_PROTECT;
  logic        MODEL_LARGE, FM_LARGE, RUN, TRACE_VLD;
  logic [3:0]  AREA;
  logic [12:0] ADDR;
  logic [6:0]  BIT_NUM;
  logic [15:0] WDATA, RDATA, SYS_FLAGS, TRACE_WORD;
  logic [2:0]  ERR;
  logic [7:0]  TEMP_BITS;
  int          miscompares, samples_checked;

  pdam_top pdam_top_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ(REQ), .WR(WR), .BIT_MODE(BIT_MODE), .AREA(AREA),
    .ADDR(ADDR), .BIT_NUM(BIT_NUM), .WDATA(WDATA), .WBIT(WBIT), .MODEL_LARGE(MODEL_LARGE),
    .FM_LARGE(FM_LARGE), .RUN(RUN), .SYS_FLAGS(SYS_FLAGS), .TRACE_VLD(TRACE_VLD),
    .TRACE_WORD(TRACE_WORD), .ACK(ACK), .RDATA(RDATA), .RBIT(RBIT), .ERR(ERR), .BUSY(BUSY),
    .FM_PROTECT(FM_PROTECT), .TEMP_BITS(TEMP_BITS)
  );
  pdam_cpu_model pdam_cpu_model_i (
    .CLK_SYS(CLK_SYS), .REQ(REQ), .WR(WR), .BIT_MODE(BIT_MODE), .AREA(AREA), .ADDR(ADDR),
    .BIT_NUM(BIT_NUM), .WDATA(WDATA), .WBIT(WBIT)
  );

  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic b, input logic [3:0] a, input logic [12:0] ad,
                    input logic [6:0] bn, input logic [15:0] d, input logic [2:0] e);
    pdam_cpu_model_i.access(w, b, a, ad, bn, d);
    chk({15'h0, ACK}, 16'h0001);
    chk({13'h0, ERR}, {13'h0, e});
  endtask
  task automatic wrw(input logic [3:0] a, input logic [12:0] ad, input logic [15:0] d);
    op(1'b1, 1'b0, a, ad, 7'h00, d, pdam_pkg::ERR_NONE);
  endtask
  task automatic rdw(input logic [3:0] a, input logic [12:0] ad, input logic [15:0] exp);
    op(1'b0, 1'b0, a, ad, 7'h00, 16'h0000, pdam_pkg::ERR_NONE);
    chk(RDATA, exp);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 300 && BUSY !== 1'b0; n++) begin
      @(posedge CLK_SYS);
      #1;
    end
    chk({15'h0, BUSY}, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_areas();
    logic [3:0]  a [8];
    logic [12:0] w [8];
    a = '{pdam_pkg::AREA_INT_SPC, pdam_pkg::AREA_AUX, pdam_pkg::AREA_HOLD, pdam_pkg::AREA_TC,
          pdam_pkg::AREA_TC_SET, pdam_pkg::AREA_LINK, pdam_pkg::AREA_DM, pdam_pkg::AREA_FM};
    w = '{pdam_pkg::INT_LAST, pdam_pkg::AUX_LAST, pdam_pkg::HOLD_LAST, pdam_pkg::TC_LAST,
          pdam_pkg::TC_LAST, pdam_pkg::LINK_LAST, pdam_pkg::DM_LAST_SMALL, pdam_pkg::FM_LAST_SMALL};
    for (int i = 0; i < 8; i++) begin
      wrw(a[i], w[i], 16'h1230 + 16'(i));
      rdw(a[i], w[i], 16'h1230 + 16'(i));
      op(1'b0, 1'b0, a[i], (i == 0) ? pdam_pkg::SPC_LAST + 13'h1 : w[i] + 13'h1, 7'h00,
         16'h0000, pdam_pkg::ERR_RANGE);
    end
    MODEL_LARGE = 1'b1;
    FM_LARGE    = 1'b1;
    wrw(pdam_pkg::AREA_DM, pdam_pkg::DM_LAST_LARGE, 16'h6655);
    rdw(pdam_pkg::AREA_DM, pdam_pkg::DM_LAST_LARGE, 16'h6655);
    op(1'b0, 1'b0, pdam_pkg::AREA_DM, pdam_pkg::DM_LAST_LARGE + 13'h1, 7'h00, 16'h0,
       pdam_pkg::ERR_RANGE);
    wrw(pdam_pkg::AREA_FM, pdam_pkg::FM_LAST_LARGE, 16'h1999);
    rdw(pdam_pkg::AREA_FM, pdam_pkg::FM_LAST_LARGE, 16'h1999);
  endtask
  task automatic s_access();
    op(1'b0, 1'b1, pdam_pkg::AREA_DM, 13'h005, 7'h00, 16'h0000, pdam_pkg::ERR_WORD_ONLY);
    op(1'b0, 1'b0, pdam_pkg::AREA_TEMP, 13'h003, 7'h00, 16'h0000, pdam_pkg::ERR_BIT_ONLY);
    op(1'b1, 1'b1, pdam_pkg::AREA_TEMP, 13'h007, 7'h00, 16'h0001, pdam_pkg::ERR_NONE);
    chk({8'h00, TEMP_BITS}, 16'h0080);
    op(1'b0, 1'b1, pdam_pkg::AREA_TEMP, 13'h008, 7'h00, 16'h0000, pdam_pkg::ERR_RANGE);
    op(1'b0, 1'b1, pdam_pkg::AREA_HOLD, 13'h002, 7'h10, 16'h0000, pdam_pkg::ERR_BITNUM);
    op(1'b0, 1'b0, 4'ha, 13'h000, 7'h00, 16'h0000, pdam_pkg::ERR_RANGE);
  endtask
  task automatic s_hold();
    wrw(pdam_pkg::AREA_HOLD, pdam_pkg::HOLD_LAST, 16'ha5c3);
    op(1'b0, 1'b1, pdam_pkg::AREA_HOLD, pdam_pkg::HOLD_LAST, 7'h0f, 16'h0, 3'h0);
    chk({15'h0, RBIT}, 16'h0001);
    op(1'b1, 1'b1, pdam_pkg::AREA_HOLD, pdam_pkg::HOLD_LAST, 7'h02, 16'h1, 3'h0);
    rdw(pdam_pkg::AREA_HOLD, pdam_pkg::HOLD_LAST, 16'ha5c7);
  endtask
  task automatic s_flags();
    rdw(pdam_pkg::AREA_INT_SPC, pdam_pkg::SPC_LAST, 16'h5a01);
    op(1'b1, 1'b0, pdam_pkg::AREA_INT_SPC, pdam_pkg::SPC_LAST, 7'h00, 16'h0,
       pdam_pkg::ERR_READONLY);
    SYS_FLAGS = 16'hc3a5;
    rdw(pdam_pkg::AREA_INT_SPC, pdam_pkg::SPC_LAST, 16'hc3a5);
    wrw(pdam_pkg::AREA_TC, 13'h003, 16'h0000);
    op(1'b0, 1'b1, pdam_pkg::AREA_TC, 13'h003, 7'h00, 16'h0, pdam_pkg::ERR_NONE);
    chk({15'h0, RBIT}, 16'h0001);
    op(1'b1, 1'b1, pdam_pkg::AREA_TC, 13'h003, 7'h00, 16'h1, pdam_pkg::ERR_READONLY);
    wrw(pdam_pkg::AREA_AUX, pdam_pkg::AUX_FMWP_WORD, 16'h8000);
    op(1'b1, 1'b0, pdam_pkg::AREA_FM, 13'h00a, 7'h00, 16'h0, pdam_pkg::ERR_READONLY);
    chk({15'h0, FM_PROTECT}, 16'h0001);
    wrw(pdam_pkg::AREA_AUX, pdam_pkg::AUX_FMWP_WORD, 16'h0000);
    chk({15'h0, FM_PROTECT}, 16'h0000);
    wrw(pdam_pkg::AREA_FM, 13'h00a, 16'h0a0a);
    wrw(pdam_pkg::AREA_INT_SPC, 13'h0fe, 16'h7777);
    rdw(pdam_pkg::AREA_INT_SPC, 13'h0fe, 16'h7777);
  endtask
  task automatic s_trace();
    for (int i = 0; i <= 250; i++) begin
      @(posedge CLK_SYS);
      #1;
      TRACE_VLD  = 1'b1;
      TRACE_WORD = 16'(i);
    end
    @(posedge CLK_SYS);
    #1;
    TRACE_VLD = 1'b0;
    rdw(pdam_pkg::AREA_TRACE, 13'h000, 16'h00fa);
    rdw(pdam_pkg::AREA_TRACE, pdam_pkg::TRACE_LAST, 16'h00f9);
    op(1'b0, 1'b0, pdam_pkg::AREA_TRACE, 13'h0fa, 7'h00, 16'h0, pdam_pkg::ERR_RANGE);
    op(1'b1, 1'b0, pdam_pkg::AREA_TRACE, 13'h000, 7'h00, 16'h0, pdam_pkg::ERR_READONLY);
  endtask
  task automatic s_clear();
    wrw(pdam_pkg::AREA_INT_SPC, 13'h005, 16'h0f0f);
    wrw(pdam_pkg::AREA_HOLD, 13'h005, 16'hbeef);
    wrw(pdam_pkg::AREA_INT_SPC, 13'h0ed, 16'h2370);
    RUN = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk({15'h0, BUSY}, 16'h0001);
    wait_idle();
    rdw(pdam_pkg::AREA_INT_SPC, 13'h005, 16'h0000);
    rdw(pdam_pkg::AREA_INT_SPC, pdam_pkg::INT_LAST, 16'h0000);
    rdw(pdam_pkg::AREA_HOLD, 13'h005, 16'hbeef);
    rdw(pdam_pkg::AREA_INT_SPC, 13'h0ed, 16'h2370);
    chk({8'h00, TEMP_BITS}, 16'h0080);
    RUN = 1'b1;
  endtask
  task automatic s_reset();
    wrw(pdam_pkg::AREA_HOLD, 13'h006, 16'hc0de);
    RST_N = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk({6'h00, ACK, BUSY, TEMP_BITS}, 16'h0100);
    RST_N = 1'b1;
    wait_idle();
    rdw(pdam_pkg::AREA_HOLD, 13'h006, 16'hc0de);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK_SYS);
    miscompares++;
    results();
  end

  initial begin
    RST_N       = 1'b0;
    RUN         = 1'b1;
    MODEL_LARGE = 1'b0;
    FM_LARGE    = 1'b0;
    SYS_FLAGS   = 16'h5a01;
    TRACE_VLD   = 1'b0;
    TRACE_WORD  = 16'h0000;
    repeat (8) @(posedge CLK_SYS);
    #1;
    RST_N = 1'b1;
    wait_idle();
    rdw(pdam_pkg::AREA_INT_SPC, 13'h0c8, 16'h0000);
    chk({8'h00, TEMP_BITS}, 16'h0000);
    s_areas();
    s_access();
    s_hold();
    s_flags();
    s_trace();
    s_clear();
    s_reset();
    results();
  end
endmodule
